// file: logic/ssar_top.sv
// Purpose: Frame sequencer of a serial 12-bit SAR converter readout.
// Assumes: sclk and cs_b are synchronous to clk and slower than it.
// Notes:   Serial edges are found by comparing with last cycle's level.
// How it works
// R01: Full frame spans sixteen serial clock cycles.
// R02: Short frame is fourteen or fifteen cycles.
// R03: Result leaves MSB first toward LSB.
// R04: Null bit then bits on falling edges.
// R05: Host captures on the following rising edge.
// R06: Continued clocking repeats the word LSB first.
// R07: Each bit is driven once resolved.
// R08: Sampling lasts from select fall onward.
// R09: Hold at second fall after aperture delay.
// R10: Twos complement, saturating at 7FF and 800.
// R11: Inputs isolated until conversion ends.
// R12: Only a new select fall starts conversion.
// R13: Output enabled with null at second fall.
// R14: Early select rise floats output, no repeat.
// R15: Power down at select rise, 14th or 16th.
// R16: Host holds serial clock low at select fall; the code also accepts it high, which enables the 14th-fall power down.
// R17: Select high floats output, clears counter.
`timescale 1ns/1ps
`default_nettype none
module ssar_top
   import ssar_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             sclk,
   input  wire logic             cs_b,
   input  wire logic             cmp_hi,
   output logic                  dout_o,
   output logic                  dout_oe_o,
   output logic                  track_o,
   output logic                  hold_o,
   output logic                  analog_pd_o,
   output logic                  digital_pd_o,
   output logic [RES_W-1:0]      dac_code_o,
   output logic [RES_W-1:0]      result_o
);
   ssar_ctl_t        r_reg;
   ssar_ctl_t        r_next;
   logic             fall;
   logic             cs_fall;
   logic             sar_start;
   logic             sar_step;
   logic [CNT_W-1:0] cnt;
   logic [IDX_W-1:0] rep_idx;

   assign fall    = r_reg.sclk_q & ~sclk;
   assign cs_fall = r_reg.cs_q & ~cs_b;
   assign cnt     = r_reg.fcnt + 5'h01;
   assign rep_idx = IDX_W'(cnt - FALL_LSB);

   always_comb begin
      r_next            = r_reg;
      r_next.sclk_q     = sclk;
      r_next.cs_q       = cs_b;
      r_next.digital_pd = cs_b;                    // [R15]
      sar_start         = 1'b0;
      sar_step          = 1'b0;
      if (cs_b) begin
         // Select high ends any frame at once and parks all but first_fall and the SAR trial and result. [R17]
         r_next.st        = SSAR_IDLE;             // [R14]
         r_next.fcnt      = '0;
         r_next.dout_oe   = 1'b0;
         r_next.dout      = 1'b0;
         r_next.track     = 1'b0;
         r_next.hold      = 1'b0;
         r_next.ap_cnt    = '0;
         r_next.analog_pd = 1'b1;                  // [R15]
      end else if (cs_fall) begin
         r_next.st         = SSAR_ACQ;             // [R12]
         r_next.fcnt       = '0;
         r_next.track      = 1'b1;                 // [R08]
         r_next.analog_pd  = 1'b0;
         // A high clock here means the next edge is a fall. [R02]
         r_next.first_fall = sclk;
         sar_start         = 1'b1;
      end else begin
         if (r_reg.ap_cnt != '0) begin
            r_next.ap_cnt = r_reg.ap_cnt - 2'h1;
            if (r_reg.ap_cnt == 2'h1) begin
               r_next.track = 1'b0;                // [R09]
               r_next.hold  = 1'b1;                // [R11]
            end
         end
         if (fall && r_reg.st != SSAR_IDLE && r_reg.st != SSAR_DONE) begin
            r_next.fcnt = cnt;
            unique case (r_reg.st)
               SSAR_ACQ: begin
                  if (cnt == FALL_NULL) begin
                     r_next.ap_cnt  = APERTURE_CYC; // [R09]
                     r_next.dout_oe = 1'b1;         // [R13]
                     r_next.dout    = 1'b0;         // [R04]
                     r_next.st      = SSAR_CONV;
                  end
               end
               SSAR_CONV: begin
                  // The bit goes out the moment it is decided. [R07]
                  r_next.dout = (cnt == FALL_MSB) ? ~cmp_hi : cmp_hi; // [R03]
                  sar_step    = 1'b1;
                  if (cnt == FALL_LSB) begin
                     r_next.st   = SSAR_REPEAT;
                     r_next.hold = 1'b0;            // [R11]
                     if (r_reg.first_fall) begin
                        r_next.analog_pd = 1'b1;    // [R15]
                     end
                  end
               end
               SSAR_REPEAT: begin
                  if (cnt == FALL_REP_END) begin
                     r_next.dout_oe = 1'b0;         // [R14]
                     r_next.dout    = 1'b0;
                     r_next.st      = SSAR_DONE;    // [R01]
                  end else begin
                     r_next.dout = result_o[rep_idx]; // [R06]
                  end
                  if (cnt == FALL_PD_LONG) begin
                     r_next.analog_pd = 1'b1;       // [R15]
                  end
               end
               default: begin
                  r_next.st = SSAR_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg            <= '0;
         r_reg.st         <= SSAR_IDLE;
         r_reg.sclk_q     <= 1'b0;
         r_reg.cs_q       <= 1'b1;
         r_reg.analog_pd  <= 1'b1;
         r_reg.digital_pd <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ssar_sar u_sar (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (sar_start),
      .step    (sar_step),
      .cmp_hi  (cmp_hi),
      .trial_o (dac_code_o),
      .word_o  (result_o)
   );

   assign dout_o       = r_reg.dout;
   assign dout_oe_o    = r_reg.dout_oe;
   assign track_o      = r_reg.track;
   assign hold_o       = r_reg.hold;
   assign analog_pd_o  = r_reg.analog_pd;
   assign digital_pd_o = r_reg.digital_pd;

   a_float_idle: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
      cs_b |=> !dout_oe_o && r_reg.fcnt == '0)
      else $error("output not floated while select high");
   a_null_enable: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
      $rose(dout_oe_o) |-> !dout_o && r_reg.fcnt == FALL_NULL)
      else $error("output enabled without null bit at second fall");
   a_msb_sign: assert property (@(posedge clk) disable iff (!rst_b) // [R03]
      (!cs_b && fall && r_reg.st == SSAR_CONV && cnt == FALL_MSB)
      |=> dout_o == !$past(cmp_hi))
      else $error("msb is not the inverted first decision");
   a_bit_live: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
      (!cs_b && fall && r_reg.st == SSAR_CONV && cnt != FALL_MSB)
      |=> dout_o == $past(cmp_hi) && dout_oe_o)
      else $error("resolved bit not driven at once");
   a_repeat_end: assert property (@(posedge clk) disable iff (!rst_b) // [R06]
      (r_reg.fcnt == FALL_REP_END) |-> !dout_oe_o && r_reg.st != SSAR_REPEAT)
      else $error("output still driven after repeated word");
   a_pd_select: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
      cs_b |=> analog_pd_o && digital_pd_o)
      else $error("select high did not power down");
   a_hold_iso: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
      hold_o |-> !track_o && r_reg.st inside {SSAR_CONV, SSAR_REPEAT})
      else $error("inputs not isolated during conversion");
   a_no_restart: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
      (r_reg.st == SSAR_DONE && !cs_b) |=> r_reg.st == SSAR_DONE)
      else $error("extra clocks started a new conversion");
   a_track_start: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
      (!cs_b && r_reg.cs_q) |=> track_o && !hold_o && r_reg.st == SSAR_ACQ)
      else $error("sampling did not start at select fall");
   a_hold_delay: assert property (@(posedge clk) disable iff (!rst_b) // [R09]
      $rose(dout_oe_o) && !cs_b ##1 !cs_b |=> hold_o)
      else $error("hold not reached one aperture after second fall");
   a_pd_short: assert property (@(posedge clk) disable iff (!rst_b) // [R02]
      (!cs_b && fall && r_reg.st == SSAR_CONV && cnt == FALL_LSB
       && r_reg.first_fall) |=> analog_pd_o)
      else $error("short frame did not power down at fourteenth fall");
endmodule : ssar_top
`default_nettype wire

// file: logic/ssar_pkg.sv
// Purpose: Shared constants and state types of the serial converter readout.
// Assumes: Falling serial clock edges are counted from one after select falls.
// Notes:   All timing is counted in system clock cycles or serial clock falls.
`default_nettype none
package ssar_pkg;
   localparam int unsigned RES_W        = 12;
   localparam int unsigned CNT_W        = 5;
   localparam int unsigned IDX_W        = 4;
   localparam logic [CNT_W-1:0] FALL_NULL     = 5'h02;
   localparam logic [CNT_W-1:0] FALL_MSB      = 5'h03;
   localparam logic [CNT_W-1:0] FALL_LSB      = 5'h0E;
   localparam logic [CNT_W-1:0] FALL_PD_LONG  = 5'h10;
   localparam logic [CNT_W-1:0] FALL_REP_END  = 5'h1A;
   localparam logic [RES_W-1:0] SAR_MID       = 12'h800;
   localparam logic [IDX_W-1:0] SAR_TOP       = 4'hB;
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned APERTURE_NS    = 6;
   // Least time, so rounded up, and never below one cycle.
   localparam int unsigned APERTURE_CYC_I =
      (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] APERTURE_CYC =
      (APERTURE_CYC_I < 1) ? 2'h1 : 2'(APERTURE_CYC_I);

   typedef enum logic [2:0] {
      SSAR_IDLE, SSAR_ACQ, SSAR_CONV, SSAR_REPEAT, SSAR_DONE
   } ssar_state_t;

   typedef struct packed {
      logic [RES_W-1:0] trial;
      logic [RES_W-1:0] word;
      logic [IDX_W-1:0] idx;
   } ssar_sar_t;

   typedef struct packed {
      ssar_state_t      st;
      logic             sclk_q;
      logic             cs_q;
      logic [CNT_W-1:0] fcnt;
      logic             first_fall;
      logic [1:0]       ap_cnt;
      logic             dout;
      logic             dout_oe;
      logic             track;
      logic             hold;
      logic             analog_pd;
      logic             digital_pd;
   } ssar_ctl_t;
endpackage : ssar_pkg
`default_nettype wire

// file: logic/ssar_sar.sv
// Purpose: Successive-approximation trial register and result word.
// Assumes: cmp_hi answers the trial code presented on trial_o.
// Notes:   Trial is offset binary; the result word is two's complement.
`timescale 1ns/1ps
`default_nettype none
module ssar_sar
   import ssar_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             start,
   input  wire logic             step,
   input  wire logic             cmp_hi,
   output logic [RES_W-1:0]      trial_o,
   output logic [RES_W-1:0]      word_o
);
   ssar_sar_t s_reg;
   ssar_sar_t s_next;

   always_comb begin
      s_next = s_reg;
      if (start) begin
         s_next.trial = SAR_MID;
         s_next.idx   = SAR_TOP;
      end else if (step) begin
         // Full-scale inputs settle on all ones or all zeros, which
         // become 7FF and 800 once the sign bit is flipped. [R10]
         s_next.trial[s_reg.idx] = cmp_hi;
         if (s_reg.idx != '0) begin
            s_next.trial[s_reg.idx - 4'h1] = 1'b1;
            s_next.idx = s_reg.idx - 4'h1;
         end
         s_next.word = {~s_next.trial[RES_W-1], s_next.trial[RES_W-2:0]};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign trial_o = s_reg.trial;
   assign word_o  = s_reg.word;
endmodule : ssar_sar
`default_nettype wire

// file: sim/ssar_afe_model.sv
// Purpose: Analog front end facing the readout: sampler and comparator.
// Assumes: vin is an offset binary code; it may move during a conversion.
// Notes:   The held sample follows vin only while the track switch is closed.
`timescale 1ns/1ps
`default_nettype none
module ssar_afe_model
   import ssar_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             track,
   input  wire logic [RES_W-1:0] vin,
   input  wire logic [RES_W-1:0] dac_code,
   output logic                  cmp_hi
);
   logic [RES_W-1:0] held_reg;

   // Only the track switch admits vin, so a late isolation corrupts codes.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) held_reg <= '0;
      else if (track) held_reg <= vin;
   end

   assign cmp_hi = held_reg >= dac_code;
endmodule : ssar_afe_model
`default_nettype wire

// file: sim/tb_ssar_top.sv
// Purpose: Self-checking bench of the serial converter readout.
// Assumes: Host inputs change on falling clk; sclk half period is 3 clk.
// Notes:   Expected pins are queued per sclk fall and compared at the rise.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("FAIL %0t: got %h exp %h", $time, g, e); end end
module tb_ssar_top
   import ssar_pkg::*;
();
   logic             clk = 1'h0, rst_b = 1'h0, sclk = 1'h0, cs_b = 1'h1;
   logic             cmp_hi, dout_o, dout_oe_o, track_o, hold_o;
   logic             analog_pd_o, digital_pd_o, sclk_q = 1'h0;
   logic [RES_W-1:0] vin = '0, dac_code_o, result_o;
   logic [4:0]       expq[$];
   logic [4:0]       me;
   logic [31:0]      seed = 32'h28;
   int               fail_count = 0, num_checks = 0;

   always #4 clk = ~clk;

   ssar_top uut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
      .cmp_hi(cmp_hi), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
      .track_o(track_o), .hold_o(hold_o), .analog_pd_o(analog_pd_o),
      .digital_pd_o(digital_pd_o), .dac_code_o(dac_code_o),
      .result_o(result_o));
   ssar_afe_model afe (.clk(clk), .rst_b(rst_b), .track(track_o),
      .vin(vin), .dac_code(dac_code_o), .cmp_hi(cmp_hi));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic report_and_stop();
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // One frame of nf sclk falls; each fall notes the pins due at its rise.
   task automatic frame(input logic [RES_W-1:0] v, input int nf,
                        input logic hi);
      logic [RES_W-1:0] x;
      logic [4:0]       e;
      x = v ^ SAR_MID;
      // A high clock at the select fall makes the first edge a fall, the
      // only way to reach the fourteenth-fall power down.
      sclk = hi;
      @(negedge clk);
      vin = v;
      cs_b = 1'h0;   // sclk is low at the select fall unless hi
      repeat (3) @(negedge clk);
      `CHK(digital_pd_o, 1'h0)
      `CHK(dac_code_o, SAR_MID)
      sclk = 1'h1;
      repeat (3) @(negedge clk);
      for (int n = 1; n <= nf; n++) begin
         sclk = 1'h0;
         if (n == 3) vin = ~v;
         e[4] = n >= 2 && n <= 25;
         e[3] = (n >= 3 && n <= 14) ? x[14-n] :
                (n >= 15 && n <= 25) ? x[n-14] : 1'h0;
         e[2] = n >= 2 && n < 14;
         e[1] = n < 2;
         e[0] = n >= (hi ? 14 : 16);
         expq.push_back(e);
         repeat (3) @(negedge clk);
         sclk = 1'h1;   // host captures on this rise
         repeat (3) @(negedge clk);
      end
      `CHK(result_o, x)
      cs_b = 1'h1;
      repeat (2) @(negedge clk);
      `CHK({dout_oe_o, analog_pd_o, digital_pd_o}, 3'h3)
      sclk = 1'h0;
      repeat (3) @(negedge clk);
      sclk = 1'h1;
      repeat (3) @(negedge clk);
      sclk = 1'h0;
      repeat (3) @(negedge clk);
      `CHK(track_o, 1'h0)
   endtask : frame

   always @(posedge clk) begin
      sclk_q <= sclk;
      if (sclk && !sclk_q && !cs_b && expq.size() > 0) begin
         me = expq.pop_front();
         // Look once the edge has settled, not in its own time step.
         @(negedge clk);
         `CHK({dout_oe_o, dout_o & dout_oe_o, hold_o, track_o, analog_pd_o}, me)
      end
   end

   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      logic [RES_W-1:0] vals [4];
      int               nfs [8];
      vals = '{12'hFFF, 12'h000, 12'h800, 12'h7FF};
      nfs = '{26, 30, 14, 15, 16, 26, 14, 26};
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_b = 1'h1;
      for (int i = 0; i < 8; i++) begin
         frame(i < 4 ? vals[i] : RES_W'(rnd()), nfs[i], i == 2 || i == 5);
      end
      `CHK(expq.size(), 0)
      report_and_stop();
   end
endmodule : tb_ssar_top
`undef CHK
`default_nettype wire
